/* File: tmr_map.vh */
/*
 * Register offsets, field positions, masks, top values and counts for the 16-bit timer.
 * Assumes byte-wide registers on a plain strobe port; 16-bit values are byte pairs.
 */
`ifndef TMR_MAP_VH
`define TMR_MAP_VH
`define TMR_OFF_CTRL_A    8'h00
`define TMR_OFF_CTRL_B    8'h01
`define TMR_OFF_CTRL_C    8'h02
`define TMR_OFF_CNT_L     8'h04
`define TMR_OFF_CNT_H     8'h05
`define TMR_OFF_CAP_L     8'h06
`define TMR_OFF_CAP_H     8'h07
`define TMR_OFF_CMPA_L    8'h08
`define TMR_OFF_CMPA_H    8'h09
`define TMR_OFF_CMPB_L    8'h0A
`define TMR_OFF_CMPB_H    8'h0B
`define TMR_OFF_IRQ_EN    8'h0C
`define TMR_OFF_IRQ_FLG   8'h0D
`define TMR_OFF_GLOBAL    8'h0E
`define TMR_OFF_ACK       8'h0F
`define TMR_B_FILT        7
`define TMR_B_EDGE        6
`define TMR_C_FORCE_A     7
`define TMR_C_FORCE_B     6
`define TMR_IRQ_CAP       5
`define TMR_IRQ_MB        2
`define TMR_IRQ_MA        1
`define TMR_IRQ_OVF       0
`define TMR_IRQ_MASK      8'h27
`define TMR_CTRL_B_MASK   8'hDF
`define TMR_FILT_SAMPLES  4
`define TMR_FILT_LAST     2'd3
`define TMR_TOP_MAX       16'hFFFF
`define TMR_TOP_8         16'h00FF
`define TMR_TOP_9         16'h01FF
`define TMR_TOP_10        16'h03FF
`endif

/* File: tmr_core.v */
/*
 * 16-bit timer/counter with two compare channels, input capture, prescaler,
 * external count pin, forced compare strobes and a shared high-byte latch.
 * Assumes one clock, capture and count pins asynchronous to it, comparator on it, and a byte-wide strobe port.
 */
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`include "tmr_map.vh"

// How it works
// - Noise filter needs four equal samples
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture disabled when capture register is top
// - Clock select: stop, div 1..1024
// - Codes 6,7 count external pin edges
// - Force strobe acts on output in non-PWM
// - Force sets no flag, no clear
// - Force bits and low bits read zero
// - Byte pairs through shared high latch, compare reads direct
// - Counter write blocks next match
// - Compare registers matched against counter continuously
// - Capture source pin or comparator
// - Interrupt needs enable, global, flag
// - Unused enable and flag bits read zero
// - Capture flag at top when capture top
// - Match flag sets cycle after equality
// - Flags clear by vector or write one
// - Overflow flag point follows waveform mode
// - Waveform mode chooses top, update, overflow
// - Non-PWM output codes: off, toggle, clear, set
module tmr_core (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       capture_input_pin,
  input  wire       comparator_out,
  input  wire       external_count_pin,
  output reg        waveform_out_a,
  output reg        waveform_out_b,
  output wire       waveform_en_a,
  output wire       waveform_en_b,
  output wire       capture_irq,
  output wire       match_a_irq,
  output wire       match_b_irq,
  output wire       overflow_irq
);
  // Count direction for the dual-slope modes
  localparam DIR_UP   = 1'b0;
  localparam DIR_DOWN = 1'b1;

  reg  [7:0]  ctrl_a_reg;
  reg  [7:0]  ctrl_b_reg;
  reg  [7:0]  irq_en_reg;
  reg  [7:0]  irq_flg_reg;
  reg         global_en_reg;
  reg  [7:0]  high_latch_reg;
  reg  [15:0] counter_value_reg;
  reg  [15:0] compare_value_a_reg;
  reg  [15:0] compare_value_b_reg;
  reg  [15:0] buf_a_reg;
  reg  [15:0] buf_b_reg;
  reg  [15:0] capture_register_reg;
  reg         dir_reg;
  reg         block_match_reg;
  reg         hit_a_reg;
  reg         hit_b_reg;
  reg  [9:0]  presc_reg;
  reg  [2:0]  cap_sync_reg;
  reg  [2:0]  ext_sync_reg;
  reg  [1:0]  filt_cnt_reg;
  reg         filt_out_reg;
  reg         cap_prev_reg;
  reg         cap_pin_reg;
  reg         ext_prev_reg;

  // Field views of the control registers
  wire [3:0] waveform_mode = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
  wire [2:0] clock_select_field = ctrl_b_reg[2:0];
  wire       capture_filter_enable = ctrl_b_reg[`TMR_B_FILT];
  wire       capture_edge_select = ctrl_b_reg[`TMR_B_EDGE];
  wire       use_comparator = ctrl_a_reg[2];
  wire [1:0] compare_output_mode_a = ctrl_a_reg[7:6];
  wire [1:0] compare_output_mode_b = ctrl_a_reg[5:4];

  // Mode decode for top, buffering and overflow point
  wire cap_top = (waveform_mode == 4'd8) || (waveform_mode == 4'd10) ||
                 (waveform_mode == 4'd12) || (waveform_mode == 4'd14);
  wire cmpa_top = (waveform_mode == 4'd4) || (waveform_mode == 4'd9) ||
                  (waveform_mode == 4'd11) || (waveform_mode == 4'd15);
  wire non_pwm = (waveform_mode == 4'd0) || (waveform_mode == 4'd4) ||
                 (waveform_mode == 4'd12);
  wire fast_pwm = (waveform_mode == 4'd5) || (waveform_mode == 4'd6) ||
                  (waveform_mode == 4'd7) || (waveform_mode == 4'd14) ||
                  (waveform_mode == 4'd15);
  wire dual_slope = !non_pwm && !fast_pwm;
  wire upd_bottom = (waveform_mode == 4'd8) || (waveform_mode == 4'd9);

  // Reserved mode 13 falls back to the full 16-bit range
  reg [15:0] top_val;
  always @* begin
    top_val = `TMR_TOP_MAX;
    if (cap_top)
      top_val = capture_register_reg;
    else if (cmpa_top)
      top_val = compare_value_a_reg;
    else if (waveform_mode[1:0] == 2'd1 && !waveform_mode[3])
      top_val = `TMR_TOP_8;
    else if (waveform_mode[1:0] == 2'd2 && !waveform_mode[3])
      top_val = `TMR_TOP_9;
    else if (waveform_mode[1:0] == 2'd3 && !waveform_mode[3])
      top_val = `TMR_TOP_10;
  end

  // Prescaler taps and external pin edges
  // Count pin edges compare the agreed level with the last stable one
  wire ext_fall = ext_prev_reg && (ext_sync_reg[2:1] == 2'b00);
  wire ext_rise = !ext_prev_reg && (ext_sync_reg[2:1] == 2'b11);
  reg  tick;
  always @* begin
    case (clock_select_field)
      3'd1:    tick = 1'b1;
      3'd2:    tick = (presc_reg[2:0] == 3'd7);
      3'd3:    tick = (presc_reg[5:0] == 6'd63);
      3'd4:    tick = (presc_reg[7:0] == 8'd255);
      3'd5:    tick = (presc_reg == 10'd1023);
      3'd6:    tick = ext_fall;
      3'd7:    tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Capture source, filter and edge detect
  // Comparator source skips the synchroniser: it comes from logic on this clock
  wire cap_raw = use_comparator ? comparator_out : cap_pin_reg;
  wire cap_level = capture_filter_enable ? filt_out_reg : cap_raw;
  wire cap_edge = capture_edge_select ? (cap_level && !cap_prev_reg)
                                      : (!cap_level && cap_prev_reg);
  wire cap_event = cap_edge && !cap_top;

  // Equality is sampled on a tick and flagged one clock cycle later
  wire at_top = (counter_value_reg == top_val);
  wire at_bottom = (counter_value_reg == 16'h0000);
  wire eq_a = (counter_value_reg == compare_value_a_reg);
  wire eq_b = (counter_value_reg == compare_value_b_reg);

  // Write decodes shared by the flag and counter logic
  wire wr_cnt_l = reg_write && (reg_addr == `TMR_OFF_CNT_L);
  wire wr_flags = reg_write && (reg_addr == `TMR_OFF_IRQ_FLG);
  wire force_a = reg_write && (reg_addr == `TMR_OFF_CTRL_C) &&
                 reg_wdata[`TMR_C_FORCE_A] && non_pwm;
  wire force_b = reg_write && (reg_addr == `TMR_OFF_CTRL_C) &&
                 reg_wdata[`TMR_C_FORCE_B] && non_pwm;
  wire ack_wr = reg_write && (reg_addr == `TMR_OFF_ACK);

  // Overflow set point per mode
  wire ovf_set = tick && (non_pwm ? (counter_value_reg == `TMR_TOP_MAX)
                        : fast_pwm ? at_top
                        : (at_bottom && dir_reg == DIR_DOWN));

  // Flag set events; set wins over any clear
  wire [7:0] flag_set = {2'b00,
                         cap_top ? (tick && at_top) : cap_event,
                         2'b00, hit_b_reg, hit_a_reg, ovf_set};
  // Write one clears, vector acknowledge clears, zero leaves alone
  wire [7:0] flag_clr = ((wr_flags ? reg_wdata : 8'h00) |
                         (ack_wr ? reg_wdata : 8'h00)) & `TMR_IRQ_MASK;

  // Requests are levels; software clears the flag to drop them
  assign capture_irq  = global_en_reg && irq_en_reg[`TMR_IRQ_CAP] &&
                        irq_flg_reg[`TMR_IRQ_CAP];
  assign match_b_irq  = global_en_reg && irq_en_reg[`TMR_IRQ_MB] &&
                        irq_flg_reg[`TMR_IRQ_MB];
  assign match_a_irq  = global_en_reg && irq_en_reg[`TMR_IRQ_MA] &&
                        irq_flg_reg[`TMR_IRQ_MA];
  assign overflow_irq = global_en_reg && irq_en_reg[`TMR_IRQ_OVF] &&
                        irq_flg_reg[`TMR_IRQ_OVF];
  // Pin enable follows the output mode only
  assign waveform_en_a = (compare_output_mode_a != 2'b00);
  assign waveform_en_b = (compare_output_mode_b != 2'b00);

  // Output action: non-PWM codes, else simple PWM compare behaviour
  function out_next;
    input       cur;
    input [1:0] mode;
    input       hit;
    input       topev;
    input       npwm;
    input       down;
    begin
      out_next = cur;
      if (hit && (npwm || mode == 2'b01))
        out_next = (mode == 2'b01) ? !cur : (mode == 2'b11);
      else if (hit && mode[1])
        out_next = down ? !mode[0] : mode[0];
      if (topev && !npwm && mode[1])
        out_next = !mode[0];
    end
  endfunction

  // Fast PWM outputs also act at top
  wire pwm_top_ev = tick && fast_pwm && at_top;

  // Synchronisers: decisions read only the second and third stages
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cap_sync_reg <= 3'b000;
      ext_sync_reg <= 3'b000;
      cap_prev_reg <= 1'b0;
      cap_pin_reg  <= 1'b0;
      ext_prev_reg <= 1'b0;
      filt_cnt_reg <= 2'd0;
      filt_out_reg <= 1'b0;
      presc_reg    <= 10'd0;
    end else begin
      cap_sync_reg <= {cap_sync_reg[1:0], capture_input_pin};
      ext_sync_reg <= {ext_sync_reg[1:0], external_count_pin};
      cap_prev_reg <= cap_level;
      if (ext_sync_reg[2] == ext_sync_reg[1])
        ext_prev_reg <= ext_sync_reg[2];
      // Capture level moves only once the second and third stages agree
      if (cap_sync_reg[2] == cap_sync_reg[1])
        cap_pin_reg <= cap_sync_reg[2];
      // Free-running prescaler; a clock select change does not restart it
      presc_reg <= presc_reg + 10'd1;
      // Output moves on the fourth sample in a row that differs from it
      if (cap_raw == filt_out_reg)
        filt_cnt_reg <= 2'd0;
      else if (filt_cnt_reg == `TMR_FILT_LAST) begin
        filt_cnt_reg <= 2'd0;
        filt_out_reg <= cap_raw;
      end else
        filt_cnt_reg <= filt_cnt_reg + 2'd1;
    end
  end

  // Counter, compare, capture and register writes
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a_reg           <= 8'h00;
      ctrl_b_reg           <= 8'h00;
      irq_en_reg           <= 8'h00;
      irq_flg_reg          <= 8'h00;
      global_en_reg        <= 1'b0;
      high_latch_reg       <= 8'h00;
      counter_value_reg    <= 16'h0000;
      compare_value_a_reg  <= 16'h0000;
      compare_value_b_reg  <= 16'h0000;
      buf_a_reg            <= 16'h0000;
      buf_b_reg            <= 16'h0000;
      capture_register_reg <= 16'h0000;
      dir_reg              <= DIR_UP;
      block_match_reg      <= 1'b0;
      hit_a_reg            <= 1'b0;
      hit_b_reg            <= 1'b0;
      waveform_out_a       <= 1'b0;
      waveform_out_b       <= 1'b0;
    end else begin
      // Matches are held off for one tick after a counter write
      hit_a_reg <= tick && eq_a && !block_match_reg;
      hit_b_reg <= tick && eq_b && !block_match_reg;
      if (tick)
        block_match_reg <= 1'b0;
      irq_flg_reg <= (irq_flg_reg & ~flag_clr) | flag_set;
      // Force acts on the pin only: no flag, no counter clear
      waveform_out_a <= out_next(waveform_out_a, compare_output_mode_a,
                                 hit_a_reg || force_a, pwm_top_ev, non_pwm,
                                 dir_reg);
      waveform_out_b <= out_next(waveform_out_b, compare_output_mode_b,
                                 hit_b_reg || force_b, pwm_top_ev, non_pwm,
                                 dir_reg);
      // A capture in the same cycle as a software write loses to the write
      if (cap_event)
        capture_register_reg <= counter_value_reg;
      // Dual-slope modes turn at top and bottom; others wrap or clear
      if (tick) begin
        if (dual_slope) begin
          if (at_top) begin
            dir_reg <= DIR_DOWN;
            counter_value_reg <= counter_value_reg - 16'd1;
          end else if (at_bottom && dir_reg == DIR_DOWN) begin
            dir_reg <= DIR_UP;
            counter_value_reg <= counter_value_reg + 16'd1;
          end else if (dir_reg == DIR_DOWN)
            counter_value_reg <= counter_value_reg - 16'd1;
          else
            counter_value_reg <= counter_value_reg + 16'd1;
        end else if (at_top && waveform_mode != 4'd0)
          counter_value_reg <= 16'h0000;
        else
          counter_value_reg <= counter_value_reg + 16'd1;
        // Buffered compare values load at top or bottom
        if (!non_pwm && ((upd_bottom && at_bottom) || (!upd_bottom && at_top))) begin
          compare_value_a_reg <= buf_a_reg;
          compare_value_b_reg <= buf_b_reg;
        end
      end
      // Register writes come last, so they win over the count on the same edge
      if (reg_write) begin
        if (reg_addr == `TMR_OFF_CTRL_A)
          ctrl_a_reg <= reg_wdata;
        else if (reg_addr == `TMR_OFF_CTRL_B)
          ctrl_b_reg <= reg_wdata & `TMR_CTRL_B_MASK;
        else if (reg_addr == `TMR_OFF_IRQ_EN)
          irq_en_reg <= reg_wdata & `TMR_IRQ_MASK;
        else if (reg_addr == `TMR_OFF_GLOBAL)
          global_en_reg <= reg_wdata[0];
        else if (reg_addr == `TMR_OFF_CNT_H || reg_addr == `TMR_OFF_CAP_H ||
                 reg_addr == `TMR_OFF_CMPA_H || reg_addr == `TMR_OFF_CMPB_H)
          high_latch_reg <= reg_wdata;
        else if (wr_cnt_l) begin
          counter_value_reg <= {high_latch_reg, reg_wdata};
          block_match_reg   <= 1'b1;
        end else if (reg_addr == `TMR_OFF_CAP_L)
          capture_register_reg <= {high_latch_reg, reg_wdata};
        else if (reg_addr == `TMR_OFF_CMPA_L) begin
          buf_a_reg <= {high_latch_reg, reg_wdata};
          if (non_pwm)
            compare_value_a_reg <= {high_latch_reg, reg_wdata};
        end else if (reg_addr == `TMR_OFF_CMPB_L) begin
          buf_b_reg <= {high_latch_reg, reg_wdata};
          if (non_pwm)
            compare_value_b_reg <= {high_latch_reg, reg_wdata};
        end
      end else if (reg_read) begin
        // Low-byte read snapshots the high byte for the following high read
        if (reg_addr == `TMR_OFF_CNT_L)
          high_latch_reg <= counter_value_reg[15:8];
        else if (reg_addr == `TMR_OFF_CAP_L)
          high_latch_reg <= capture_register_reg[15:8];
      end
    end
  end

  // Read port: data stand one cycle after the strobe, zero elsewhere
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (!reg_read)
      reg_rdata <= 8'h00;
    else if (reg_addr == `TMR_OFF_CTRL_A)
      reg_rdata <= ctrl_a_reg;
    else if (reg_addr == `TMR_OFF_CTRL_B)
      reg_rdata <= ctrl_b_reg;
    else if (reg_addr == `TMR_OFF_CTRL_C)
      reg_rdata <= 8'h00;
    else if (reg_addr == `TMR_OFF_CNT_L)
      reg_rdata <= counter_value_reg[7:0];
    else if (reg_addr == `TMR_OFF_CAP_L)
      reg_rdata <= capture_register_reg[7:0];
    else if (reg_addr == `TMR_OFF_CMPA_L)
      reg_rdata <= compare_value_a_reg[7:0];
    else if (reg_addr == `TMR_OFF_CMPB_L)
      reg_rdata <= compare_value_b_reg[7:0];
    else if (reg_addr == `TMR_OFF_CNT_H || reg_addr == `TMR_OFF_CAP_H)
      reg_rdata <= high_latch_reg;
    else if (reg_addr == `TMR_OFF_CMPA_H)
      reg_rdata <= compare_value_a_reg[15:8];
    else if (reg_addr == `TMR_OFF_CMPB_H)
      reg_rdata <= compare_value_b_reg[15:8];
    else if (reg_addr == `TMR_OFF_IRQ_EN)
      reg_rdata <= irq_en_reg;
    else if (reg_addr == `TMR_OFF_IRQ_FLG)
      reg_rdata <= irq_flg_reg;
    else if (reg_addr == `TMR_OFF_GLOBAL)
      reg_rdata <= {7'd0, global_en_reg};
    else
      reg_rdata <= 8'h00;
  end
endmodule // tmr_core

/* File: tmr_pins.sv */
/* Far-side model of the pins: capture input, comparator output and count pin.
   Assumes the bench calls drive(); levels change just after a rising edge. */
`timescale 1ns/1ns
module tmr_pins (
  input  wire logic clock,
  output logic      capture_input_pin,
  output logic      comparator_out,
  output logic      external_count_pin
);
  initial begin
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    external_count_pin = 1'b0;
  end
  // Each level is held n cycles; shorter holds are lost in the core's synchroniser
  task automatic drive(input int which, input logic v, input int n);
    @(posedge clock);
    case (which)
      0: capture_input_pin <= v;
      1: comparator_out <= v;
      default: external_count_pin <= v;
    endcase
    repeat (n) @(posedge clock);
  endtask
endmodule // tmr_pins

/* File: tmr_core_asserts.sv */
/* Checker for the timer core ports, bound to the core.
   Assumes it sees only the core's ports; control writes are shadowed here. */
`timescale 1ns/1ns
module tmr_core_asserts (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       waveform_out_a,
  input wire logic       waveform_out_b,
  input wire logic       waveform_en_a,
  input wire logic       waveform_en_b,
  input wire logic       capture_irq,
  input wire logic       match_a_irq,
  input wire logic       match_b_irq,
  input wire logic       overflow_irq
);
  logic [7:0] ctl_a_reg, ctl_b_reg, en_reg;
  logic       glob_reg;
  logic [3:0] wgm;
  logic       quiet;
  assign wgm = {ctl_b_reg[4:3], ctl_a_reg[1:0]};
  // Forces judged only with the counter stopped, so no real match interferes
  assign quiet = ctl_b_reg[2:0] == 3'h0 && (wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_a_reg <= 8'h00;
      ctl_b_reg <= 8'h00;
      en_reg <= 8'h00;
      glob_reg <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        8'h00: ctl_a_reg <= reg_wdata;
        8'h01: ctl_b_reg <= reg_wdata;
        8'h0C: en_reg <= reg_wdata;
        8'h0E: glob_reg <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_force_a;
    reg_write && reg_addr == 8'h02 && reg_wdata[7] && quiet;
  endsequence
  sequence s_force_b;
    reg_write && reg_addr == 8'h02 && reg_wdata[6] && quiet;
  endsequence
  a_ctrlc_zero: assert property (reg_read && reg_addr == 8'h02 |=> reg_rdata == 8'h00)
    else $error("control C read not zero");
  a_unused_bits: assert property (reg_read && reg_addr[7:1] == 7'h06
    |=> (reg_rdata & 8'hD8) == 8'h00) else $error("unused enable or flag bit read one");
  a_global_gate: assert property (!glob_reg
    |-> !(capture_irq || match_a_irq || match_b_irq || overflow_irq))
    else $error("interrupt request without global enable");
  a_enable_gate: assert property ((!capture_irq || en_reg[5]) && (!match_b_irq || en_reg[2])
    && (!match_a_irq || en_reg[1]) && (!overflow_irq || en_reg[0]))
    else $error("interrupt request without its enable");
  a_wave_enable: assert property (waveform_en_a == (ctl_a_reg[7:6] != 2'b00)
    && waveform_en_b == (ctl_a_reg[5:4] != 2'b00)) else $error("output enable wrong");
  a_force_set_a: assert property (s_force_a ##0 ctl_a_reg[7:6] == 2'b11 |=> waveform_out_a)
    else $error("forced set on channel A missed");
  a_force_toggle_a: assert property (s_force_a ##0 ctl_a_reg[7:6] == 2'b01
    |=> waveform_out_a != $past(waveform_out_a)) else $error("forced toggle on A missed");
  a_force_clear_b: assert property (s_force_b ##0 ctl_a_reg[5:4] == 2'b10
    |=> !waveform_out_b) else $error("forced clear on channel B missed");
endmodule // tmr_core_asserts
bind tmr_core tmr_core_asserts tmr_core_asserts_i (.clock, .sys_rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .waveform_out_a, .waveform_out_b, .waveform_en_a,
  .waveform_en_b, .capture_irq, .match_a_irq, .match_b_irq, .overflow_irq);

/* File: tmr_core_tb.sv */
/* Self-checking bench for the timer core: map, byte pairs, prescaler, count pin,
   compare flags, forced compares, capture and overflow.
   Assumes tmr_pins on the pin side and the checker bound to the core. */
`timescale 1ns/1ns
module tmr_core_tb;
  logic        clock, sys_rst, reg_write, reg_read;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        cap_pin, cmp_pin, cnt_pin, out_a, out_b, irq_c, irq_a, irq_b, irq_o;
  logic [15:0] v, w;
  int          n_errors, comparisons, i, k;
  int          divs[5] = '{1, 8, 64, 256, 1024};
  tmr_core tmr_core_i (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .capture_input_pin(cap_pin), .comparator_out(cmp_pin), .external_count_pin(cnt_pin),
    .waveform_out_a(out_a), .waveform_out_b(out_b), .waveform_en_a(), .waveform_en_b(),
    .capture_irq(irq_c), .match_a_irq(irq_a), .match_b_irq(irq_b), .overflow_irq(irq_o));
  tmr_pins tmr_pins_i (.clock(clock), .capture_input_pin(cap_pin),
    .comparator_out(cmp_pin), .external_count_pin(cnt_pin));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= x;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Return once the write has landed, so callers see settled outputs
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 x = reg_rdata;
  endtask
  // High byte first on writes, low byte first on reads: writes and counter or capture reads pass the shared latch
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr(a + 8'h01, x[15:8]);
    wr(a, x[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    rd(a, x[7:0]);
    rd(a + 8'h01, x[15:8]);
  endtask
  task automatic flags(input logic [7:0] m, input logic [7:0] e);
    rd(8'h0D, d);
    chk("flags", {8'h00, d & m}, {8'h00, e});
  endtask
  function automatic logic force_next(input logic [1:0] m, input logic prev);
    return (m == 2'b01) ? ~prev : m[0];
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  initial begin
    {sys_rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'h4, 16'h0000};
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'he563_2bf7));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    wr(8'h02, 8'hFF);
    rd(8'h02, d);
    chk("ctrl_c", {8'h00, d}, 16'h0000);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, d);
    chk("irq_en", {8'h00, d}, 16'h0027);
    flags(8'hFF, 8'h00);
    rd(8'h03, d);
    chk("unmapped", {8'h00, d}, 16'h0000);
    for (i = 0; i < 6; i++) begin
      v = (i < 3) ? 16'hFFFF : 16'($urandom);
      k = (i % 3 == 0) ? 4 : 6 + 2 * (i % 3);
      wr16(8'(k), v);
      rd16(8'(k), w);
      chk("pair", w, v);
    end
    $display("test map and pairs done");
    for (i = 0; i < 5; i++) begin
      wr16(8'h04, 16'h0000);
      wr(8'h01, 8'(i + 1));
      repeat (6 * divs[i]) @(posedge clock);
      wr(8'h01, 8'h00);
      rd16(8'h04, v);
      chk("prescale", 16'(v >= 5 && v <= 7 + 3 / divs[i]), 16'h0001);
    end
    for (i = 6; i < 8; i++) begin
      wr16(8'h04, 16'h0000);
      wr(8'h01, 8'(i));
      repeat (10) tmr_pins_i.drive(2, ~cnt_pin, 4);
      repeat (6) @(posedge clock);
      wr(8'h01, 8'h00);
      rd16(8'h04, v);
      chk("ext_count", v, 16'h0005);
    end
    $display("test clock select done");
    wr(8'h0C, 8'h02);
    wr(8'h0E, 8'h01);
    wr16(8'h08, 16'h0010);
    wr16(8'h0A, 16'h000E);
    // Counter written equal to compare A: the first tick's match must be dropped
    wr16(8'h04, 16'h0010);
    wr(8'h0D, 8'hFF);
    wr(8'h01, 8'h01);
    repeat (20) @(posedge clock);
    chk("blocked", {15'h0000, irq_a}, 16'h0000);
    wr(8'h01, 8'h00);
    wr16(8'h04, 16'h000C);
    wr(8'h0D, 8'hFF);
    wr(8'h01, 8'h01);
    k = 0;
    while (irq_a !== 1'b1 && k < 20) begin
      @(posedge clock);
      #1 k = k + 1;
    end
    wr(8'h01, 8'h00);
    chk("match_time", 16'(k >= 3 && k <= 7), 16'h0001);
    flags(8'h06, 8'h06);
    chk("irq_b", {15'h0000, irq_b}, 16'h0000);
    wr(8'h0E, 8'h00);
    chk("gated", {15'h0000, irq_a}, 16'h0000);
    wr(8'h0E, 8'h01);
    wr(8'h0D, 8'h00);
    flags(8'h06, 8'h06);
    wr(8'h0D, 8'h02);
    flags(8'h06, 8'h04);
    wr(8'h0F, 8'h04);
    flags(8'h06, 8'h00);
    $display("test compare done");
    for (i = 0; i < 4; i++) begin
      k = (i % 3) + 1;
      wr(8'h00, 8'(k * 80));
      v[1:0] = {force_next(2'(k), out_b), force_next(2'(k), out_a)};
      wr(8'h02, 8'hC0);
      chk("force", {14'h0000, out_b, out_a}, {14'h0000, v[1:0]});
    end
    flags(8'hFF, 8'h00);
    $display("test force done");
    wr(8'h00, 8'h00);
    for (i = 0; i < 2; i++) begin
      v = 16'($urandom);
      wr16(8'h04, v);
      wr(8'h01, 8'(i * 64));
      wr(8'h0D, 8'hFF);
      tmr_pins_i.drive(0, 1'b1, 8);
      flags(8'h20, 8'(i * 32));
      wr(8'h0D, 8'h20);
      tmr_pins_i.drive(0, 1'b0, 8);
      flags(8'h20, 8'(32 - i * 32));
      rd16(8'h06, w);
      chk("captured", w, v);
    end
    wr(8'h01, 8'hC0);
    wr(8'h0D, 8'hFF);
    tmr_pins_i.drive(0, 1'b1, 2);
    tmr_pins_i.drive(0, 1'b0, 8);
    flags(8'h20, 8'h00);
    tmr_pins_i.drive(0, 1'b1, 8);
    flags(8'h20, 8'h20);
    tmr_pins_i.drive(0, 1'b0, 8);
    wr(8'h00, 8'h04);
    wr(8'h01, 8'h40);
    wr(8'h0D, 8'hFF);
    tmr_pins_i.drive(1, 1'b1, 8);
    flags(8'h20, 8'h20);
    tmr_pins_i.drive(1, 1'b0, 2);
    // Capture register as top: comparator edges ignored, flag comes from top instead
    wr16(8'h04, 16'h0000);
    wr16(8'h06, 16'h0005);
    wr(8'h01, 8'h58);
    wr(8'h0D, 8'hFF);
    tmr_pins_i.drive(1, 1'b1, 8);
    flags(8'h20, 8'h00);
    wr(8'h01, 8'h59);
    repeat (8) @(posedge clock);
    wr(8'h0C, 8'h20);
    chk("cap_irq", {15'h0000, irq_c}, 16'h0001);
    wr(8'h01, 8'h00);
    $display("test capture done");
    wr(8'h00, 8'h00);
    wr16(8'h04, 16'hFFFE);
    wr(8'h0D, 8'hFF);
    wr(8'h01, 8'h01);
    wr(8'h01, 8'h00);
    flags(8'h01, 8'h01);
    wr(8'h0C, 8'h01);
    chk("ovf_irq", {15'h0000, irq_o}, 16'h0001);
    $display("test overflow done");
    end_of_test();
  end
endmodule // tmr_core_tb
